/* rtl/asrmc_pkg.sv */
// package: constants and types for the static ram host controller
//------------------------------------------------------------------
//------------------------------------------------------------------
package asrmc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MEM_BYTES = 32768;
  // access cycle figures in ns; longest published cycle
  localparam int CYCLE_NS = 25;
  localparam int CLK_NS = 40;
  // least time rounds up, at least one cycle
  localparam int ACC_CYC_RAW = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (ACC_CYC_RAW < 1) ? 1 : ACC_CYC_RAW;
  localparam logic [3:0] ACC_CNT = 4'(ACC_CYC);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;

  typedef enum logic [3:0] {
    ASRMC_IDLE  = 4'h1,
    ASRMC_READ  = 4'h2,
    ASRMC_WRITE = 4'h4,
    ASRMC_DONE  = 4'h8
  } asrmc_state_t;
endpackage

/* rtl/asrmc_pins_if.sv */
// interface: pin-level control group between sequencer and pin driver
`timescale 1ns/100ps
interface asrmc_pins_if;
  import asrmc_pkg::*;
  logic              wr_act;     // write strobe asserted
  logic              rd_act;     // output drive asserted
  logic              drv_data;   // host drives data lines
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  modport seq (output wr_act, output rd_act, output drv_data,
               output addr, output wdata);
  modport drv (input wr_act, input rd_act, input drv_data,
               input addr, input wdata);
endinterface

/* rtl/asrmc_pin_drv.sv */
// module: registered pin driver for the static ram
`timescale 1ns/100ps
module asrmc_pin_drv (
  // clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          nrst_in,
  // from sequencer
  asrmc_pins_if.drv                          pins,
  // memory pins
  output logic [asrmc_pkg::ADDR_W-1:0]       addr_out,
  output logic [asrmc_pkg::DATA_W-1:0]       data_out,
  output logic                               data_oe_out,
  output logic                               select_low_out,
  output logic                               write_strobe_low_out,
  output logic                               output_drive_low_out,
  output logic                               chip_enable_out
);
  import asrmc_pkg::*;

  // all pins from flops so strobes never glitch
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      addr_out             <= ADDR_ZERO;
      data_out             <= DATA_ZERO;
      data_oe_out          <= 1'b0;
      select_low_out       <= 1'b0;
      write_strobe_low_out <= 1'b1;
      output_drive_low_out <= 1'b0;
      chip_enable_out      <= 1'b1;
    end else begin
      addr_out             <= pins.addr;
      data_out             <= pins.wdata;
      // keep the byte on the lines one cycle past the rising strobe: data hold
      data_oe_out          <= pins.drv_data || !write_strobe_low_out;
      select_low_out       <= 1'b0;
      write_strobe_low_out <= ~pins.wr_act;
      output_drive_low_out <= ~pins.rd_act;
      chip_enable_out      <= 1'b1;
    end
  end
endmodule

/* rtl/asrmc_top.sv */
// module: host controller that reads and writes the static ram via its pins
`timescale 1ns/100ps
module asrmc_top (
  // clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          nrst_in,
  // user request
  input  wire logic                          req_valid_in,
  input  wire logic                          req_write_in,
  input  wire logic [asrmc_pkg::ADDR_W-1:0]  req_addr_in,
  input  wire logic [asrmc_pkg::DATA_W-1:0]  req_wdata_in,
  output logic                               req_ready_out,
  // user answer
  output logic                               rsp_valid_out,
  output logic [asrmc_pkg::DATA_W-1:0]       rsp_rdata_out,
  // memory pins
  output logic [asrmc_pkg::ADDR_W-1:0]       addr_out,
  output logic [asrmc_pkg::DATA_W-1:0]       data_out,
  output logic                               data_oe_out,
  input  wire logic [asrmc_pkg::DATA_W-1:0]  data_in,
  output logic                               select_low_out,
  output logic                               write_strobe_low_out,
  output logic                               output_drive_low_out,
  output logic                               chip_enable_out
);
  import asrmc_pkg::*;

  // behaviour in short:
  //   one request at a time; ready is high only while idle
  //   a write holds the strobe low for the access time, then lets it rise
  //   the pin driver keeps the byte on the lines one cycle past the strobe
  //   a read lowers output drive, waits, then samples through two flops
  //   the answer is a one-cycle pulse; the byte stays until the next read
  //   select and enable stay active; nothing else shares the part
  // limitation: no back-to-back accesses, a write costs three cycles
  // and a read six, traded for pins that come straight from flops

  // pin intent towards the registered pin driver
  asrmc_pins_if pins ();

  // sequencer state and its wait counter
  asrmc_state_t      state_ff, nxt_state;
  logic [3:0]        cnt_ff, nxt_cnt;
  // request held for the whole access
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  // data pin synchroniser
  logic [DATA_W-1:0] sync1_ff, sync2_ff;
  // read answer
  logic              rsp_ff;
  logic [DATA_W-1:0] rdata_ff;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // one step down the wait counter, cut back to the counter width
  function automatic logic [3:0] cnt_dec(input logic [3:0] cnt);
    return 4'(cnt - CNT_ONE);
  endfunction

  // state test shared by the decode wires below
  function automatic logic is_state(input asrmc_state_t cur, input asrmc_state_t want);
    return (cur == want);
  endfunction

  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  // one-hot state tests, used by the handshake, the pins and the answer
  wire in_idle   = is_state(state_ff, ASRMC_IDLE);
  wire take_req  = req_valid_in && in_idle;
  wire cnt_done  = (cnt_ff == CNT_ZERO);
  wire in_read   = is_state(state_ff, ASRMC_READ);
  wire in_write  = is_state(state_ff, ASRMC_WRITE);
  wire in_done   = is_state(state_ff, ASRMC_DONE);
  // the data pin echo needs two more flops before it is safe to sample
  wire rd_sample = in_done && cnt_done;

  // ready straight from the state; valid and data outputs from flops
  assign req_ready_out = in_idle;
  assign rsp_valid_out = rsp_ff;
  assign rsp_rdata_out = rdata_ff;

  // pin intent; host only drives data while the device floats (write strobe low)
  assign pins.wr_act   = in_write;
  // read intent stays on through DONE so the byte is driven while it settles
  assign pins.rd_act   = in_read || (in_done && !rsp_ff);
  assign pins.drv_data = in_write;
  assign pins.addr     = addr_ff;
  assign pins.wdata    = wdata_ff;

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  // write: IDLE, then WRITE for ACC_CNT plus one cycles, then IDLE
  // read: IDLE, READ for ACC_CNT plus one cycles, DONE for three, IDLE
  // every wait state leaves on a zero count, so the counter never wraps
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ASRMC_IDLE: begin
        if (req_valid_in) begin
          nxt_state = req_write_in ? ASRMC_WRITE : ASRMC_READ;
          nxt_cnt   = ACC_CNT;
        end
      end
      ASRMC_READ: begin
        if (cnt_done) begin
          nxt_state = ASRMC_DONE;
          // pin stage plus sync stage before the byte can be taken
          nxt_cnt   = 4'(CNT_ONE + CNT_ONE);
        end else begin
          nxt_cnt = cnt_dec(cnt_ff);
        end
      end
      ASRMC_WRITE: begin
        if (cnt_done) begin
          // the pin driver keeps the byte on the lines one cycle longer
          nxt_state = ASRMC_IDLE;          // strobe rises; byte is stored
        end else begin
          nxt_cnt = cnt_dec(cnt_ff);
        end
      end
      ASRMC_DONE: begin
        // the answer pulse leaves with this step, so ready rises in the same cycle as it
        if (cnt_done) begin
          nxt_state = ASRMC_IDLE;
        end else begin
          nxt_cnt = cnt_dec(cnt_ff);
        end
      end
      default: begin
        nxt_state = ASRMC_IDLE;
        nxt_cnt   = CNT_ZERO;
      end
    endcase
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  // reset lands in idle so the write strobe cannot fall before a request; output drive resets low
  // state and counter
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_ff <= ASRMC_IDLE;
      cnt_ff   <= CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  //------------------------------------------------------------
  // request capture
  //------------------------------------------------------------
  // captured once so the pins hold still even if the user moves on
  // request capture
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      addr_ff  <= ADDR_ZERO;
      wdata_ff <= DATA_ZERO;
    end else if (take_req) begin
      addr_ff  <= req_addr_in;
      wdata_ff <= req_wdata_in;
    end
  end

  //------------------------------------------------------------
  // pin input synchroniser
  //------------------------------------------------------------
  // a single flop could hand a half-settled level to the answer register
  // data pins come from outside the clock domain: two flops
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sync1_ff <= DATA_ZERO;
      sync2_ff <= DATA_ZERO;
    end else begin
      sync1_ff <= data_in;
      sync2_ff <= sync1_ff;
    end
  end

  //------------------------------------------------------------
  // read answer
  //------------------------------------------------------------
  // only the second sync flop is read here, never the first
  // read answer, one-cycle pulse
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rsp_ff   <= 1'b0;
      rdata_ff <= DATA_ZERO;
    end else begin
      rsp_ff <= rd_sample;
      if (rd_sample) begin
        rdata_ff <= sync2_ff;
      end
    end
  end

  //------------------------------------------------------------
  // pin driver
  //------------------------------------------------------------
  // registered pins; data release lags the strobe by one cycle
  asrmc_pin_drv u_drv (
    .clock_in             (clock_in),
    .nrst_in              (nrst_in),
    .pins                 (pins),
    .addr_out             (addr_out),
    .data_out             (data_out),
    .data_oe_out          (data_oe_out),
    .select_low_out       (select_low_out),
    .write_strobe_low_out (write_strobe_low_out),
    .output_drive_low_out (output_drive_low_out),
    .chip_enable_out      (chip_enable_out)
  );
endmodule

/* dv/asrmc_chk.sv */
// checker: host-side pin rules of the static ram controller
`timescale 1ns/100ps
module asrmc_chk (
  // clock and reset
  input wire logic                         clock_in,
  input wire logic                         nrst_in,
  // user side
  input wire logic                         req_valid_in,
  input wire logic                         req_write_in,
  input wire logic [asrmc_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [asrmc_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic                         req_ready_out,
  input wire logic                         rsp_valid_out,
  // memory pins
  input wire logic [asrmc_pkg::ADDR_W-1:0] addr_out,
  input wire logic [asrmc_pkg::DATA_W-1:0] data_out,
  input wire logic                         data_oe_out,
  input wire logic                         select_low_out,
  input wire logic                         write_strobe_low_out,
  input wire logic                         output_drive_low_out,
  input wire logic                         chip_enable_out
);
  import asrmc_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  wire take = req_valid_in && req_ready_out;
  a_select_held: assert property (!select_low_out)
    else $error("select line not held low");
  a_enable_held: assert property (chip_enable_out)
    else $error("enable line not held high");
  a_addr_follows: assert property (take |-> ##2 addr_out == $past(req_addr_in, 2))
    else $error("address pins do not carry the taken address");
  a_write_drives: assert property (take && req_write_in |-> ##2
    (!write_strobe_low_out && data_oe_out && data_out == $past(req_wdata_in, 2)))
    else $error("write cycle pins wrong");
  a_strobe_owns_bus: assert property (!write_strobe_low_out |-> data_oe_out)
    else $error("write strobe low with data lines released");
  a_read_answer: assert property (take && !req_write_in |-> ##1 !rsp_valid_out[*5] ##1
    rsp_valid_out ##1 !rsp_valid_out)
    else $error("read answer not a single pulse six cycles on");
  a_data_hold: assert property ($rose(write_strobe_low_out) |-> data_oe_out)
    else $error("data released as the write strobe rose");
  a_no_contention: assert property (data_oe_out |-> output_drive_low_out)
    else $error("host drives data while the device is asked to drive");
  c_write: cover property (take && req_write_in);
  c_read: cover property (take && !req_write_in);
  c_answer: cover property (rsp_valid_out);
endmodule

bind asrmc_top asrmc_chk chk_u (.clock_in, .nrst_in, .req_valid_in, .req_write_in,
  .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .addr_out, .data_out,
  .data_oe_out, .select_low_out, .write_strobe_low_out, .output_drive_low_out,
  .chip_enable_out);

/* dv/asrmc_ram_mdl.sv */
// model: behavioural 32k by 8 static ram seen at its pins
`timescale 1ns/100ps
module asrmc_ram_mdl (
  // pins driven by the host
  input wire logic [asrmc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [asrmc_pkg::DATA_W-1:0] dq_in,
  input wire logic                         select_low_in,
  input wire logic                         write_strobe_low_in,
  input wire logic                         output_drive_low_in,
  input wire logic                         chip_enable_in,
  // data drive back to the wire
  output logic     [asrmc_pkg::DATA_W-1:0] dq_out,
  output logic                             dq_oe_out
);
  import asrmc_pkg::*;
  logic [DATA_W-1:0] mem [MEM_BYTES];
  // deselect or disable blocks every access
  wire acc = !select_low_in && chip_enable_in;
  // the byte on the lines as the strobe rises is kept, as a late write does
  always @(posedge write_strobe_low_in) begin
    if (acc) begin
      mem[addr_in] <= dq_in;
    end
  end
  assign dq_oe_out = acc && write_strobe_low_in && !output_drive_low_in;
  assign dq_out = mem[addr_in];
endmodule

/* dv/async_static_ram_32k_by_8_tb.sv */
// testbench: host controller against a behavioural static ram
`timescale 1ns/100ps
module async_static_ram_32k_by_8_tb;
  import asrmc_pkg::*;
  logic              clock_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic              req_valid_in = 1'b0;
  logic              req_write_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = 15'h0000;
  logic [DATA_W-1:0] req_wdata_in = 8'h00;
  wire               req_ready_out, rsp_valid_out, data_oe_out, dev_oe;
  wire               select_low_out, write_strobe_low_out, output_drive_low_out, chip_enable_out;
  wire  [DATA_W-1:0] rsp_rdata_out, data_out, dev_q, dq;
  wire  [ADDR_W-1:0] addr_out;
  int                err_count = 0;
  int                n_checks = 0;
  always #20 clock_in = ~clock_in;
  // undriven wire shows the inverse, so a stale byte never passes
  assign dq = data_oe_out ? data_out : (dev_oe ? dev_q : ~data_out);
  asrmc_top dut_u (.clock_in, .nrst_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .addr_out, .data_out,
    .data_oe_out, .data_in(dq), .select_low_out, .write_strobe_low_out,
    .output_drive_low_out, .chip_enable_out);
  asrmc_ram_mdl ram_u (.addr_in(addr_out), .dq_in(dq), .select_low_in(select_low_out),
    .write_strobe_low_in(write_strobe_low_out), .output_drive_low_in(output_drive_low_out),
    .chip_enable_in(chip_enable_out), .dq_out(dev_q), .dq_oe_out(dev_oe));
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hold the request until an edge sees ready high
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int i;
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (req_ready_out !== 1'b1 && i < 20);
    req_valid_in <= 1'b0;
    if (req_ready_out !== 1'b1) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    int i;
    issue(1'b0, a, 8'h00);
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (rsp_valid_out !== 1'b1 && i < 20);
    if (rsp_valid_out !== 1'b1) begin
      err_count++;
      conclude();
    end
    chk("read byte", e, rsp_rdata_out);
  endtask
  task automatic t_reset();
    chk("select", 8'h00, {7'h00, select_low_out});
    chk("enable", 8'h01, {7'h00, chip_enable_out});
    chk("data oe", 8'h00, {7'h00, data_oe_out});
    $display("test reset done");
  endtask
  task automatic t_edges();
    issue(1'b1, 15'h0000, 8'ha5);
    issue(1'b1, 15'h7fff, 8'h5a);
    issue(1'b1, 15'h4000, 8'h3c);
    rd_chk(15'h0000, 8'ha5);
    rd_chk(15'h7fff, 8'h5a);
    rd_chk(15'h4000, 8'h3c);
    $display("test edges done");
  endtask
  task automatic t_overwrite();
    issue(1'b1, 15'h0123, 8'h0f);
    issue(1'b1, 15'h0123, 8'hf0);
    rd_chk(15'h0123, 8'hf0);
    rd_chk(15'h7fff, 8'h5a);
    $display("test overwrite done");
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_edges();
    t_overwrite();
    conclude();
  end
endmodule
